// file: verilog/rfsyn_top.sv
// SPI register port, mode sequencer, carrier word and clock output.
// Assumes i_clock is the crystal clock and SPI pins are asynchronous.
`timescale 1ns/1ps
`include "rfsyn_params.svh"
module rfsyn_top #(
    parameter logic [15:0] OSC_CYCLES = 16'(`RFSYN_OSC_CYCLES),
    parameter logic [15:0] PLL_CYCLES = 16'(`RFSYN_PLL_CYCLES),
    parameter logic [15:0] RC_CYCLES = 16'(`RFSYN_RC_CYCLES)
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_spi_nss_n,
    input wire logic i_spi_sck,
    input wire logic i_spi_mosi,
    input wire logic i_low_supply_cmp,
    output logic o_spi_miso,
    output logic [5:0] o_dio,
    output logic [23:0] o_carrier_word,
    output logic o_carrier_update,
    output logic o_fast_hop_enable,
    output logic o_osc_en,
    output logic o_pll_en,
    output logic o_pll_locked,
    output logic o_pll_low_noise,
    output logic [1:0] o_pll_bandwidth,
    output logic o_tx_en,
    output logic o_rx_en,
    output logic [2:0] o_low_supply_trim,
    output logic o_rc_cal_done
);
    rfsyn_pkg::rfsyn_state_t q_ff;
    rfsyn_pkg::rfsyn_state_t nxt_q;
    logic mem_we;
    logic [7:0] mem_rdata;

    rfsyn_regmem #(.AW(7), .DW(8)) rfsyn_regmem_i (
        .i_clock(i_clock),
        .i_we(mem_we),
        .i_waddr(q_ff.spi.addr),
        .i_wdata({q_ff.spi.sh_in[6:0], q_ff.spi.mosi}),
        .i_raddr(q_ff.spi.addr),
        .o_rdata(mem_rdata)
    );

    // Pin mapping: code 3 routes the low supply flag, pin five code 0
    // carries the clock output
    function automatic logic pin_level(input logic [1:0] code,
                                       input logic is_five,
                                       input logic clk_bit,
                                       input logic low_flag);
        logic v;
        v = 1'b0;
        if (code == `RFSYN_PIN_LOWBAT) begin
            v = low_flag;
        end else if (is_five && code == `RFSYN_PIN_CLK) begin
            v = clk_bit;
        end
        return v;
    endfunction

    always_comb begin
        logic nss_f;
        logic sck_f;
        logic mosi_f;
        logic [7:0] byte_in;
        logic [7:0] rd_byte;
        logic relock;
        logic [2:0] tgt;
        logic tgt_synth;
        logic tgt_tx;
        logic clk_bit;
        logic [2:0] csel;
        nxt_q = q_ff;
        mem_we = 1'b0;
        relock = 1'b0;
        nxt_q.carrier_upd = 1'b0;
        nss_f = q_ff.spi.nss_n;
        sck_f = q_ff.spi.sck;
        mosi_f = q_ff.spi.mosi;
        // A change counts once the second and third stages agree
        nxt_q.spi.s_nss_n = {q_ff.spi.s_nss_n[1:0], i_spi_nss_n};
        nxt_q.spi.s_sck = {q_ff.spi.s_sck[1:0], i_spi_sck};
        nxt_q.spi.s_mosi = {q_ff.spi.s_mosi[1:0], i_spi_mosi};
        nxt_q.s_lowcmp = {q_ff.s_lowcmp[1:0], i_low_supply_cmp};
        if (q_ff.spi.s_nss_n[1] == q_ff.spi.s_nss_n[2]) begin
            nss_f = q_ff.spi.s_nss_n[2];
        end
        if (q_ff.spi.s_sck[1] == q_ff.spi.s_sck[2]) begin
            sck_f = q_ff.spi.s_sck[2];
        end
        if (q_ff.spi.s_mosi[1] == q_ff.spi.s_mosi[2]) begin
            mosi_f = q_ff.spi.s_mosi[2];
        end
        if (q_ff.s_lowcmp[1] == q_ff.s_lowcmp[2]) begin
            nxt_q.lowcmp = q_ff.s_lowcmp[2];
        end
        nxt_q.spi.nss_n = nss_f;
        nxt_q.spi.sck = sck_f;
        nxt_q.spi.mosi = mosi_f;
        byte_in = {q_ff.spi.sh_in[6:0], mosi_f};

        // Read mux: shadowed bytes from flops, the rest from storage
        unique case (q_ff.spi.addr)
            `RFSYN_ADDR_OPMODE: rd_byte = q_ff.opmode;
            `RFSYN_ADDR_FRF_HI: rd_byte = q_ff.frf_hi;
            `RFSYN_ADDR_FRF_MID: rd_byte = q_ff.frf_mid;
            `RFSYN_ADDR_FRF_LO: rd_byte = q_ff.carrier[7:0];
            `RFSYN_ADDR_PLL: rd_byte = q_ff.pll_cfg;
            `RFSYN_ADDR_LOWBAT: rd_byte = q_ff.lowbat;
            `RFSYN_ADDR_MAP1: rd_byte = q_ff.map1;
            `RFSYN_ADDR_MAP2: rd_byte = q_ff.map2;
            `RFSYN_ADDR_HOP: rd_byte = q_ff.hop;
            `RFSYN_ADDR_STATUS: rd_byte = {4'h0, q_ff.rc_done,
                q_ff.lowbat_flag, q_ff.pll_locked, q_ff.osc_ready};
            default: rd_byte = mem_rdata;
        endcase

        // SPI mode 0: sample on rising SCK, shift out on falling SCK
        if (nss_f) begin
            nxt_q.spi.bit_cnt = 3'h0;
            nxt_q.spi.first = 1'b1;
            nxt_q.spi.sh_out = 8'h00;
        end else if (sck_f && !q_ff.spi.sck) begin
            nxt_q.spi.sh_in = byte_in;
            nxt_q.spi.bit_cnt = q_ff.spi.bit_cnt + 3'h1;
            if (q_ff.spi.bit_cnt == 3'h7) begin
                if (q_ff.spi.first) begin
                    nxt_q.spi.first = 1'b0;
                    nxt_q.spi.wnr = byte_in[7];
                    nxt_q.spi.addr = byte_in[6:0];
                end else begin
                    nxt_q.spi.addr = q_ff.spi.addr + 7'h01;
                    if (q_ff.spi.wnr) begin
                        mem_we = 1'b1;
                        unique case (q_ff.spi.addr)
                            `RFSYN_ADDR_OPMODE: nxt_q.opmode = byte_in;
                            `RFSYN_ADDR_FRF_HI: nxt_q.frf_hi = byte_in;
                            `RFSYN_ADDR_FRF_MID: nxt_q.frf_mid = byte_in;
                            `RFSYN_ADDR_FRF_LO: begin
                                nxt_q.carrier = {q_ff.frf_hi,
                                    q_ff.frf_mid, byte_in};
                                nxt_q.carrier_upd = 1'b1;
                                // Without fast hop a retune needs relock
                                relock = !q_ff.hop[`RFSYN_HOP_BIT];
                            end
                            `RFSYN_ADDR_PLL: nxt_q.pll_cfg = byte_in;
                            `RFSYN_ADDR_LOWBAT: nxt_q.lowbat = byte_in;
                            `RFSYN_ADDR_MAP1: nxt_q.map1 = byte_in;
                            `RFSYN_ADDR_MAP2: nxt_q.map2 = byte_in;
                            `RFSYN_ADDR_HOP: nxt_q.hop = byte_in;
                            `RFSYN_ADDR_STATUS: begin
                                if (byte_in[`RFSYN_STAT_LOWBAT_BIT]) begin
                                    nxt_q.lowbat_flag = 1'b0;
                                end
                            end
                            default: ;
                        endcase
                    end
                end
            end
        end else if (!sck_f && q_ff.spi.sck) begin
            if (q_ff.spi.bit_cnt == 3'h0 && !q_ff.spi.first &&
                !q_ff.spi.wnr) begin
                nxt_q.spi.sh_out = rd_byte;
            end else begin
                nxt_q.spi.sh_out = {q_ff.spi.sh_out[6:0], 1'b0};
            end
        end

        // Set wins over the software clear
        if (q_ff.lowcmp && q_ff.lowbat[`RFSYN_LOWBAT_EN_BIT]) begin
            nxt_q.lowbat_flag = 1'b1;
        end

        // RC oscillator calibrates once after power-up
        if (!q_ff.rc_done) begin
            nxt_q.rc_cnt = q_ff.rc_cnt + 16'h0001;
            if (q_ff.rc_cnt == RC_CYCLES - 16'h0001) begin
                nxt_q.rc_done = 1'b1;
            end
        end

        // Mode sequencer
        tgt = q_ff.opmode[2:0];
        tgt_synth = tgt >= `RFSYN_MODE_FSTX && tgt <= `RFSYN_MODE_RX;
        tgt_tx = tgt == `RFSYN_MODE_FSTX || tgt == `RFSYN_MODE_TX;
        nxt_q.cnt = q_ff.cnt + 16'h0001;
        unique case (q_ff.seq)
            rfsyn_pkg::RFSYN_OSC: begin
                if (q_ff.cnt == OSC_CYCLES - 16'h0001) begin
                    nxt_q.osc_ready = 1'b1;
                    nxt_q.seq = rfsyn_pkg::RFSYN_LOCK;
                    nxt_q.cnt = 16'h0000;
                end
            end
            rfsyn_pkg::RFSYN_SLEEP: begin
                nxt_q.cnt = 16'h0000;
                if (tgt != `RFSYN_MODE_SLEEP) begin
                    nxt_q.seq = rfsyn_pkg::RFSYN_OSC;
                end
            end
            rfsyn_pkg::RFSYN_STBY: begin
                nxt_q.cnt = 16'h0000;
                if (tgt == `RFSYN_MODE_SLEEP) begin
                    nxt_q.seq = rfsyn_pkg::RFSYN_SLEEP;
                    nxt_q.osc_ready = 1'b0;
                end else if (tgt_synth) begin
                    nxt_q.seq = rfsyn_pkg::RFSYN_LOCK;
                end
            end
            rfsyn_pkg::RFSYN_LOCK: begin
                if (q_ff.cnt == PLL_CYCLES - 16'h0001) begin
                    nxt_q.cnt = 16'h0000;
                    nxt_q.seq = tgt_synth ? rfsyn_pkg::RFSYN_FS :
                        rfsyn_pkg::RFSYN_STBY;
                end
            end
            rfsyn_pkg::RFSYN_FS: begin
                nxt_q.cnt = 16'h0000;
                if (!tgt_synth) begin
                    nxt_q.seq = rfsyn_pkg::RFSYN_STBY;
                end else if (relock) begin
                    nxt_q.seq = rfsyn_pkg::RFSYN_LOCK;
                end else if (tgt == `RFSYN_MODE_TX) begin
                    nxt_q.seq = rfsyn_pkg::RFSYN_TX;
                end else if (tgt == `RFSYN_MODE_RX) begin
                    nxt_q.seq = rfsyn_pkg::RFSYN_RX;
                end
            end
            rfsyn_pkg::RFSYN_TX, rfsyn_pkg::RFSYN_RX: begin
                nxt_q.cnt = 16'h0000;
                // Crossing directions always relocks, so the two
                // enables can never overlap
                if (!tgt_synth) begin
                    nxt_q.seq = rfsyn_pkg::RFSYN_STBY;
                end else if (relock || (tgt_tx !=
                    (q_ff.seq == rfsyn_pkg::RFSYN_TX))) begin
                    nxt_q.seq = rfsyn_pkg::RFSYN_LOCK;
                end else if (tgt == `RFSYN_MODE_FSTX ||
                    tgt == `RFSYN_MODE_FSRX) begin
                    nxt_q.seq = rfsyn_pkg::RFSYN_FS;
                end
            end
        endcase
        nxt_q.osc_en = nxt_q.seq != rfsyn_pkg::RFSYN_SLEEP;
        nxt_q.pll_en = nxt_q.seq == rfsyn_pkg::RFSYN_LOCK ||
            nxt_q.seq == rfsyn_pkg::RFSYN_FS ||
            nxt_q.seq == rfsyn_pkg::RFSYN_TX ||
            nxt_q.seq == rfsyn_pkg::RFSYN_RX;
        nxt_q.pll_locked = nxt_q.pll_en &&
            nxt_q.seq != rfsyn_pkg::RFSYN_LOCK;
        nxt_q.tx_en = nxt_q.seq == rfsyn_pkg::RFSYN_TX;
        nxt_q.rx_en = nxt_q.seq == rfsyn_pkg::RFSYN_RX;
        // Low noise variant only while heading for transmit
        nxt_q.pll_low_noise = nxt_q.pll_en && tgt_tx &&
            q_ff.pll_cfg[0];

        // Clock output: fastest from a flop is half the reference
        nxt_q.div = q_ff.div + 5'h01;
        csel = q_ff.map2[2:0];
        clk_bit = 1'b0;
        if (csel <= 3'h4 && q_ff.seq != rfsyn_pkg::RFSYN_SLEEP) begin
            clk_bit = q_ff.div[csel];
        end
        for (int i = 0; i < 4; i++) begin
            nxt_q.dio[i] = pin_level(q_ff.map1[2*i +: 2], 1'b0, 1'b0,
                q_ff.lowbat_flag);
        end
        nxt_q.dio[4] = pin_level(q_ff.map2[7:6], 1'b0, 1'b0,
            q_ff.lowbat_flag);
        nxt_q.dio[5] = pin_level(q_ff.map2[5:4], 1'b1, clk_bit,
            q_ff.lowbat_flag);
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            q_ff <= '0;
            q_ff.spi.s_nss_n <= 3'h7;
            q_ff.spi.nss_n <= 1'b1;
            q_ff.spi.first <= 1'b1;
            q_ff.opmode <= `RFSYN_RST_OPMODE;
            q_ff.frf_hi <= 8'(`RFSYN_RST_FRF >> 16);
            q_ff.frf_mid <= 8'(`RFSYN_RST_FRF >> 8);
            q_ff.carrier <= `RFSYN_RST_FRF;
            q_ff.pll_cfg <= `RFSYN_RST_PLL;
            q_ff.lowbat <= `RFSYN_RST_LOWBAT;
            q_ff.map1 <= `RFSYN_RST_MAP;
            q_ff.map2 <= `RFSYN_RST_MAP;
            q_ff.hop <= `RFSYN_RST_HOP;
            q_ff.seq <= rfsyn_pkg::RFSYN_OSC;
            q_ff.osc_en <= 1'b1;
        end else begin
            q_ff <= nxt_q;
        end
    end

    // Word feeds a modulator with MOD_FRAC_BITS fractional bits
    assign o_spi_miso = q_ff.spi.sh_out[7];
    assign o_dio = q_ff.dio;
    assign o_carrier_word = q_ff.carrier;
    assign o_carrier_update = q_ff.carrier_upd;
    assign o_fast_hop_enable = q_ff.hop[`RFSYN_HOP_BIT];
    assign o_osc_en = q_ff.osc_en;
    assign o_pll_en = q_ff.pll_en;
    assign o_pll_locked = q_ff.pll_locked;
    assign o_pll_low_noise = q_ff.pll_low_noise;
    assign o_pll_bandwidth = q_ff.pll_cfg[2:1];
    assign o_tx_en = q_ff.tx_en;
    assign o_rx_en = q_ff.rx_en;
    assign o_low_supply_trim = q_ff.lowbat[2:0];
    assign o_rc_cal_done = q_ff.rc_done;
endmodule

// file: verilog/rfsyn_params.svh
// Constants for the synthesizer and clock control block.
// Assumes a 100 MHz core clock taken from the crystal oscillator.
// How it works
// - Synthesizer step is reference over 2^19; word drives 19-bit modulator.
// - Carrier word is 24 bits over three bytes, high byte lowest.
// - New frequency is applied only when the low byte is written.
// - Fast hop bit lets the host retune without a relock.
// - Crystal clock is both synthesizer reference and the logic clock.
// - Synthesizer starts by itself once the oscillator is stable.
// - Pin five carries the reference divided by 2, 4, 8, 16 or 32.
// - Clock output on at reset, stopped while asleep.
// - Low supply flag raised when supply falls under programmed threshold.
// - Low supply flag can be mapped onto any general pin.
// - Each synthesizer variant has four bandwidth presets.
// - Low noise synthesizer only in transmit; receive uses low power one.
// - Mode sequencer walks intermediate modes and calibrations quickly.
// - All configuration registers are readable and writable over SPI.
// - Transmit and receive are never enabled together.
// - Sleep timing uses an RC oscillator calibrated at power-up.
`ifndef RFSYN_PARAMS_SVH
`define RFSYN_PARAMS_SVH

`define RFSYN_ADDR_OPMODE 7'h01
`define RFSYN_ADDR_FRF_HI 7'h06
`define RFSYN_ADDR_FRF_MID 7'h07
`define RFSYN_ADDR_FRF_LO 7'h08
`define RFSYN_ADDR_PLL 7'h0A
`define RFSYN_ADDR_LOWBAT 7'h3D
`define RFSYN_ADDR_MAP1 7'h40
`define RFSYN_ADDR_MAP2 7'h41
`define RFSYN_ADDR_STATUS 7'h42
`define RFSYN_ADDR_HOP 7'h44

`define RFSYN_RST_OPMODE 8'h01
`define RFSYN_RST_FRF 24'h000000
`define RFSYN_RST_PLL 8'h00
`define RFSYN_RST_LOWBAT 8'h02
`define RFSYN_RST_MAP 8'h00
`define RFSYN_RST_HOP 8'h00

`define RFSYN_MODE_SLEEP 3'h0
`define RFSYN_MODE_STBY 3'h1
`define RFSYN_MODE_FSTX 3'h2
`define RFSYN_MODE_TX 3'h3
`define RFSYN_MODE_FSRX 3'h4
`define RFSYN_MODE_RX 3'h5

`define RFSYN_HOP_BIT 7
`define RFSYN_LOWBAT_EN_BIT 3
`define RFSYN_STAT_LOWBAT_BIT 2
`define RFSYN_PIN_CLK 2'h0
`define RFSYN_PIN_LOWBAT 2'h3
`define RFSYN_MOD_FRAC_BITS 19

`define RFSYN_CLK_PERIOD_NS 10
`define RFSYN_OSC_START_NS 250000
`define RFSYN_PLL_LOCK_NS 10000
`define RFSYN_RC_CAL_NS 5000
`define RFSYN_OSC_CYCLES \
    ((`RFSYN_OSC_START_NS + `RFSYN_CLK_PERIOD_NS - 1) / `RFSYN_CLK_PERIOD_NS)
`define RFSYN_PLL_CYCLES \
    ((`RFSYN_PLL_LOCK_NS + `RFSYN_CLK_PERIOD_NS - 1) / `RFSYN_CLK_PERIOD_NS)
`define RFSYN_RC_CYCLES \
    ((`RFSYN_RC_CAL_NS + `RFSYN_CLK_PERIOD_NS - 1) / `RFSYN_CLK_PERIOD_NS)

`endif

// file: verilog/rfsyn_pkg.sv
// Types shared by the synthesizer control block.
// Assumes rfsyn_params.svh carries all numeric constants.
package rfsyn_pkg;

    typedef enum logic [6:0] {
        RFSYN_OSC = 7'h01,
        RFSYN_SLEEP = 7'h02,
        RFSYN_STBY = 7'h04,
        RFSYN_LOCK = 7'h08,
        RFSYN_FS = 7'h10,
        RFSYN_TX = 7'h20,
        RFSYN_RX = 7'h40
    } rfsyn_seq_t;

    typedef struct packed {
        logic [2:0] s_nss_n;
        logic [2:0] s_sck;
        logic [2:0] s_mosi;
        logic nss_n;
        logic sck;
        logic mosi;
        logic [2:0] bit_cnt;
        logic first;
        logic wnr;
        logic [6:0] addr;
        logic [7:0] sh_in;
        logic [7:0] sh_out;
    } rfsyn_spi_t;

    typedef struct packed {
        rfsyn_spi_t spi;
        logic [7:0] opmode;
        logic [7:0] frf_hi;
        logic [7:0] frf_mid;
        logic [7:0] pll_cfg;
        logic [7:0] lowbat;
        logic [7:0] map1;
        logic [7:0] map2;
        logic [7:0] hop;
        logic [23:0] carrier;
        logic carrier_upd;
        logic lowbat_flag;
        logic osc_ready;
        logic pll_locked;
        logic rc_done;
        rfsyn_seq_t seq;
        logic [15:0] cnt;
        logic [15:0] rc_cnt;
        logic [4:0] div;
        logic [2:0] s_lowcmp;
        logic lowcmp;
        logic [5:0] dio;
        logic tx_en;
        logic rx_en;
        logic pll_en;
        logic osc_en;
        logic pll_low_noise;
    } rfsyn_state_t;

endpackage

// file: verilog/rfsyn_regmem.sv
// Byte-wide register storage with a registered read port.
// Assumes one writer and one reader on the same clock.
`timescale 1ns/1ps
module rfsyn_regmem #(
    parameter int AW = 7,
    parameter int DW = 8
) (
    input wire logic i_clock,
    input wire logic i_we,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [DW-1:0] i_wdata,
    input wire logic [AW-1:0] i_raddr,
    output logic [DW-1:0] o_rdata
);
    logic [DW-1:0] mem_ff [0:(1<<AW)-1];

    // No reset: unwritten bytes read undefined until software sets them
    always_ff @(posedge i_clock) begin
        if (i_we) begin
            mem_ff[i_waddr] <= i_wdata;
        end
        o_rdata <= mem_ff[i_raddr];
    end
endmodule

// file: verif/rfsyn_host_model.sv
// Host controller model driving the SPI register port in mode 0.
// Assumes its tasks are entered just after a falling clock edge.
`timescale 1ns/1ps
`include "rfsyn_params.svh"
module rfsyn_host_model (
    input wire logic i_clock,
    input wire logic i_miso,
    output logic o_nss_n,
    output logic o_sck,
    output logic o_mosi
);
    // Eight clocks a phase keeps SCK well clear of the input filter
    localparam int HALF = 8;
    initial begin
        o_nss_n = 1'b1;
        o_sck = 1'b0;
        o_mosi = 1'b0;
    end
    task automatic pause();
        repeat (HALF) @(negedge i_clock);
    endtask
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int b = 7; b >= 0; b--) begin
            o_mosi = tx[b];
            pause();
            rx[b] = i_miso;
            o_sck = 1'b1;
            pause();
            o_sck = 1'b0;
        end
    endtask
    task automatic open_frame(input logic wr, input logic [6:0] addr);
        logic [7:0] rx;
        o_nss_n = 1'b0;
        pause();
        xfer({wr, addr}, rx);
    endtask
    task automatic close_frame();
        pause();
        o_nss_n = 1'b1;
        // A released data line must not keep showing the last bit
        o_mosi = ~o_mosi;
        pause();
    endtask
    task automatic write_reg(input logic [6:0] addr, input logic [7:0] d);
        logic [7:0] rx;
        open_frame(1'b1, addr);
        xfer(d, rx);
        close_frame();
    endtask
    task automatic read_reg(input logic [6:0] addr, output logic [7:0] d);
        open_frame(1'b0, addr);
        xfer(8'h00, d);
        close_frame();
    endtask
    // High byte first, so the low byte that applies the word comes last
    task automatic write_word(input logic [23:0] w);
        logic [7:0] rx;
        open_frame(1'b1, `RFSYN_ADDR_FRF_HI);
        for (int k = 2; k >= 0; k--) begin
            xfer(w[8*k +: 8], rx);
        end
        close_frame();
    endtask
endmodule

// file: verif/rfsyn_asserts.sv
// Port checker for the synthesizer control block.
// Assumes it is bound into rfsyn_top with the top's count parameters.
`timescale 1ns/1ps
module rfsyn_asserts #(
    parameter logic [15:0] OSC_CYCLES = 16'h0014,
    parameter logic [15:0] PLL_CYCLES = 16'h000A,
    parameter logic [15:0] RC_CYCLES = 16'h0005
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_spi_nss_n,
    input wire logic o_spi_miso,
    input wire logic [5:0] o_dio,
    input wire logic [23:0] o_carrier_word,
    input wire logic o_carrier_update,
    input wire logic o_fast_hop_enable,
    input wire logic o_osc_en,
    input wire logic o_pll_en,
    input wire logic o_pll_locked,
    input wire logic o_pll_low_noise,
    input wire logic o_tx_en,
    input wire logic o_rx_en,
    input wire logic o_rc_cal_done
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    logic [15:0] lock_wait_ff;
    always_ff @(posedge i_clock) begin
        if (i_rst || !o_pll_en || o_pll_locked) begin
            lock_wait_ff <= 16'h0000;
        end else begin
            lock_wait_ff <= lock_wait_ff + 16'h0001;
        end
    end
    a_txrx_exclusive: assert property (!(o_tx_en && o_rx_en))
        else $error("transmit and receive on together");
    a_rx_low_power: assert property (o_rx_en |-> !o_pll_low_noise)
        else $error("low noise synthesizer used in receive");
    a_locked_has_pll: assert property (o_pll_locked |-> o_pll_en)
        else $error("lock reported with synthesizer off");
    a_radio_locked: assert property ((o_tx_en || o_rx_en) |-> o_pll_locked)
        else $error("radio enabled before lock");
    a_lock_wait: assert property ($rose(o_pll_locked) |->
        (lock_wait_ff + 16'h0002 >= PLL_CYCLES) &&
        (lock_wait_ff <= PLL_CYCLES + 16'h0001))
        else $error("lock wait length wrong");
    a_update_pulse: assert property (o_carrier_update |=> !o_carrier_update)
        else $error("update pulse longer than one cycle");
    a_word_on_update: assert property ($changed(o_carrier_word) |-> o_carrier_update)
        else $error("carrier word moved without update");
    a_hop_keeps_lock: assert property (o_fast_hop_enable && o_pll_locked &&
        o_carrier_update |=> o_pll_locked [*3])
        else $error("fast hop update dropped lock");
    // Relock starts on the same edge that applies the word
    a_relock_no_hop: assert property (!o_fast_hop_enable &&
        $past(o_pll_locked) && o_carrier_update |-> !o_pll_locked)
        else $error("new word applied without relock");
    a_sleep_pin_still: assert property (!o_osc_en [*2] |-> $stable(o_dio[5]))
        else $error("clock output runs while asleep");
    a_rc_sticky: assert property (o_rc_cal_done |=> o_rc_cal_done)
        else $error("calibration done flag fell");
    a_miso_idle: assert property (i_spi_nss_n [*6] |-> !o_spi_miso)
        else $error("data out driven while deselected");
    c_update: cover property (o_carrier_update);
    c_tx_on: cover property ($rose(o_tx_en));
    c_rx_on: cover property ($rose(o_rx_en));
endmodule
bind rfsyn_top rfsyn_asserts #(.OSC_CYCLES(OSC_CYCLES),
    .PLL_CYCLES(PLL_CYCLES), .RC_CYCLES(RC_CYCLES)) rfsyn_asserts_i (
    .i_clock, .i_rst, .i_spi_nss_n, .o_spi_miso, .o_dio, .o_carrier_word,
    .o_carrier_update, .o_fast_hop_enable, .o_osc_en, .o_pll_en,
    .o_pll_locked, .o_pll_low_noise, .o_tx_en, .o_rx_en, .o_rc_cal_done);

// file: verif/rf_synth_freq_config_tb_top.sv
// Self-checking bench: register sequences through the host model.
// Assumes short count parameters so every mode change is quick.
`timescale 1ns/1ps
`include "rfsyn_params.svh"
`define CHK(got, exp) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) begin \
            n_errors++; \
            $display("unexpected at %0t: got %0h expected %0h", \
                $time, (got), (exp)); \
        end \
    end
module rf_synth_freq_config_tb_top;
    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    logic i_low_supply_cmp = 1'b0;
    logic nss_n, sck, mosi, o_spi_miso, locked_q;
    logic [5:0] o_dio;
    logic [23:0] o_carrier_word;
    logic o_carrier_update, o_fast_hop_enable, o_osc_en, o_pll_en;
    logic o_pll_locked, o_pll_low_noise, o_tx_en, o_rx_en, o_rc_cal_done;
    logic [1:0] o_pll_bandwidth;
    logic [2:0] o_low_supply_trim;
    logic [7:0] rd;
    logic [4:0] st;
    int n_errors = 0;
    int checks_done = 0;
    int n_upd = 0;
    int n_relock = 0;
    int nt, r0;
    assign st = {o_rc_cal_done, o_rx_en, o_tx_en, o_pll_locked, o_pll_en};
    always #5 i_clock = ~i_clock;
    rfsyn_top #(.OSC_CYCLES(16'h0014), .PLL_CYCLES(16'h000A),
        .RC_CYCLES(16'h0005)) rfsyn_top_i (
        .i_clock, .i_rst, .i_spi_nss_n(nss_n), .i_spi_sck(sck),
        .i_spi_mosi(mosi), .i_low_supply_cmp, .o_spi_miso, .o_dio,
        .o_carrier_word, .o_carrier_update, .o_fast_hop_enable, .o_osc_en,
        .o_pll_en, .o_pll_locked, .o_pll_low_noise, .o_pll_bandwidth,
        .o_tx_en, .o_rx_en, .o_low_supply_trim, .o_rc_cal_done);
    rfsyn_host_model rfsyn_host_model_i (.i_clock, .i_miso(o_spi_miso),
        .o_nss_n(nss_n), .o_sck(sck), .o_mosi(mosi));
    always @(negedge i_clock) begin
        if (o_carrier_update === 1'b1) n_upd++;
        if (locked_q === 1'b1 && o_pll_locked === 1'b0) n_relock++;
        locked_q = o_pll_locked;
    end
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        rfsyn_host_model_i.write_reg(a, d);
    endtask
    task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
        rfsyn_host_model_i.read_reg(a, rd);
        `CHK(rd, e)
    endtask
    task automatic wait_st(input int b, input logic v);
        int k;
        k = 0;
        while (st[b] !== v && k < 200) begin
            @(negedge i_clock);
            k++;
        end
        `CHK(st[b], v)
    endtask
    task automatic count_toggles(output int n);
        logic last;
        n = 0;
        last = o_dio[5];
        repeat (32) begin
            @(negedge i_clock);
            if (o_dio[5] !== last) n++;
            last = o_dio[5];
        end
    endtask
    task automatic finish_test();
        if (n_errors == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        #300000;
        n_errors++;
        finish_test();
    end
    initial begin
        repeat (16) @(negedge i_clock);
        i_rst = 1'b0;
        `CHK(o_osc_en, 1'b1)
        `CHK(o_carrier_word, 24'h000000)
        `CHK(o_low_supply_trim, 3'h2)
        wait_st(0, 1'b1);
        wait_st(4, 1'b1);
        wait_st(0, 1'b0);
        rfsyn_host_model_i.read_reg(`RFSYN_ADDR_STATUS, rd);
        `CHK(rd[0], 1'b1)
        for (int n = 0; n < 6; n++) begin
            wr(`RFSYN_ADDR_MAP2, 8'(n));
            count_toggles(nt);
            `CHK(nt, (n < 5) ? (32 >> n) : 0)
        end
        wr(`RFSYN_ADDR_MAP2, 8'h00);
        wr(`RFSYN_ADDR_OPMODE, {5'h00, `RFSYN_MODE_SLEEP});
        count_toggles(nt);
        `CHK({o_osc_en, 8'(nt)}, 9'h000)
        wr(`RFSYN_ADDR_OPMODE, {5'h00, `RFSYN_MODE_STBY});
        wait_st(0, 1'b1);
        wait_st(0, 1'b0);
        count_toggles(nt);
        `CHK(nt, 32)
        wr(`RFSYN_ADDR_PLL, 8'h05);
        rd_chk(`RFSYN_ADDR_PLL, 8'h05);
        wr(7'h20, 8'h5A);
        rd_chk(7'h20, 8'h5A);
        for (int b = 0; b < 4; b++) begin
            wr(`RFSYN_ADDR_PLL, {5'h00, 2'(b), 1'b1});
            `CHK(o_pll_bandwidth, 2'(b))
        end
        wr(`RFSYN_ADDR_OPMODE, {5'h00, `RFSYN_MODE_TX});
        wait_st(2, 1'b1);
        `CHK({o_pll_low_noise, o_rx_en}, 2'h2)
        wr(`RFSYN_ADDR_OPMODE, {5'h00, `RFSYN_MODE_RX});
        wait_st(3, 1'b1);
        `CHK({o_pll_low_noise, o_tx_en}, 2'h0)
        wr(`RFSYN_ADDR_FRF_HI, 8'hE4);
        wr(`RFSYN_ADDR_FRF_MID, 8'hC0);
        `CHK({o_carrier_word, 8'(n_upd)}, 32'h00000000)
        rd_chk(`RFSYN_ADDR_FRF_HI, 8'hE4);
        r0 = n_relock;
        wr(`RFSYN_ADDR_FRF_LO, 8'h26);
        `CHK({o_carrier_word, 8'(n_upd)}, 32'hE4C02601)
        `CHK(n_relock, r0 + 1)
        wait_st(3, 1'b1);
        wr(`RFSYN_ADDR_HOP, 8'h80);
        `CHK(o_fast_hop_enable, 1'b1)
        r0 = n_relock;
        rfsyn_host_model_i.write_word(24'hD91A3F);
        `CHK({o_carrier_word, 8'(n_upd)}, 32'hD91A3F02)
        `CHK({o_rx_en, 8'(n_relock - r0)}, 9'h100)
        wr(`RFSYN_ADDR_LOWBAT, 8'h0B);
        `CHK(o_low_supply_trim, 3'h3)
        wr(`RFSYN_ADDR_MAP1, 8'hFF);
        wr(`RFSYN_ADDR_MAP2, 8'hF5);
        i_low_supply_cmp = 1'b1;
        repeat (8) @(negedge i_clock);
        `CHK(o_dio, 6'h3F)
        rfsyn_host_model_i.read_reg(`RFSYN_ADDR_STATUS, rd);
        `CHK(rd[2], 1'b1)
        i_low_supply_cmp = 1'b0;
        wr(`RFSYN_ADDR_STATUS, 8'h04);
        `CHK(o_dio, 6'h00)
        finish_test();
    end
endmodule
